// ### logic/spi_lock_defs.svh
`ifndef SPI_LOCK_DEFS_SVH
`define SPI_LOCK_DEFS_SVH

// ****************************************************************
// Header word layout
// ****************************************************************
`define HDR_BITS        6'd16
`define FRAME_WR_LAST   6'd31
`define TX_LAST_PLAIN   6'd32
`define TX_LAST_CRC     6'd48
`define CNT_MAX         6'h3f
`define HDR_BCAST       15
`define HDR_ADDR_MSB    14
`define HDR_ADDR_LSB    4
`define HDR_RW          3
`define HDR_CHIP_MSB    2
`define HDR_CHIP_LSB    0

// ****************************************************************
// Register map and fields
// ****************************************************************
`define CTRL_ADDR       11'h001
`define LOCK_ADDR       11'h002
`define FLAG_ADDR       11'h003
`define CTRL_RESET      16'h0000
`define CTRL_WR_MASK    16'hfe1d
`define CTRL_CRC_BIT    0
`define CTRL_RELOAD_BIT 1
`define REV_MSB         8
`define REV_LSB         5
`define LOCK_KEY_ON     16'hade1
`define LOCK_KEY_OFF    16'hade0

// ****************************************************************
// Checksum generator
// ****************************************************************
`define CRC_SEED        16'hffff
`define CRC_POLY        16'h1021

`endif

// ### logic/spi_lock_pkg.sv
`default_nettype none

// ****************************************************************
// Types shared by the serial front end
// ****************************************************************
package spi_lock_pkg;

	// Link-side frame phase
	typedef enum logic [1:0] {
		ST_HDR   = 2'b00,
		ST_WDATA = 2'b01,
		ST_RDATA = 2'b10,
		ST_SKIP  = 2'b11
	} link_state_e;

	typedef logic [15:0] word_t;

endpackage

`default_nettype wire

// ### logic/level_sync.sv
`default_nettype none

// ****************************************************************
// Two-stage level synchroniser
// ****************************************************************
module level_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk, // Destination clock
	input  wire logic [WIDTH-1:0] d,   // Level from another domain
	output logic      [WIDTH-1:0] q    // Synchronised level
);

	if (WIDTH < 1) begin : g_bad_width
		$error("level_sync needs WIDTH of at least one");
	end

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		meta_q <= d;
		sync_q <= meta_q;
	end

	assign q = sync_q;

endmodule // level_sync

`default_nettype wire

// ### logic/crc16_word.sv
`include "spi_lock_defs.svh"
`default_nettype none

// ****************************************************************
// Checksum of one 16-bit register word
// ****************************************************************
module crc16_word (
	input  wire logic [15:0] data, // Word to protect
	output logic      [15:0] crc   // Checksum after sixteen steps
);

	// One serial step: feedback is input bit xor top bit
	function automatic logic [15:0] crc_step(input logic [15:0] b, input logic a);
		logic fb;
		fb = a ^ b[15];
		crc_step = {b[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
	endfunction

	// Preset all ones, feed bit 15 first
	always_comb begin
		crc = `CRC_SEED;
		for (int i = 15; i >= 0; i--) begin
			crc = crc_step(crc, data[i]);
		end
	end

endmodule // crc16_word

`default_nettype wire

// ### logic/spi_register_access_lock.sv
`include "spi_lock_defs.svh"
`default_nettype none
// ****************************************************************
// Serial register front end with keyed configuration lock
// ****************************************************************
module spi_register_access_lock #(
	parameter logic [3:0] REVISION = 4'h1 // Arbitrary silicon version code
) (
	input  wire logic        CLK,           // System clock, 25 MHz
	input  wire logic        RST_B,         // Synchronous reset, active low
	input  wire logic [2:0]  STRAP_ADDR,    // Chip address decoded from strap
	input  wire logic        SCLK,          // Serial clock from host
	input  wire logic        CS_B,          // Chip select, active low
	input  wire logic        MOSI,          // Serial data in
	output logic             MISO_O,        // Serial data out value
	output logic             MISO_OE_B,     // Data out enable, low drives
	output logic [2:0]       CHIP_ADDR,     // Chip address in use
	output logic             LOCKED,        // Configuration protection active
	output logic             CRC_EN,        // Readback checksum enabled
	output logic [15:0]      CTRL_CFG,      // Stored control bits
	output logic             CFG_XFER,      // Pulse: send configuration across
	output logic             FLAG_CLR_STB,  // Pulse: flag register written
	output logic [15:0]      FLAG_CLR_DATA  // Value written to flag register
);

	if ($bits(REVISION) != (`REV_MSB - `REV_LSB + 1)) begin : g_bad_rev
		$error("REVISION must fit the revision field");
	end

	// ****************************************************************
	// System clock side: strap, write apply, lock
	// ****************************************************************
	logic [2:0]  strap_s;
	logic        cs_b_s;
	logic        cs_b_last_q;
	logic        strap_load_q;
	logic [2:0]  own_addr_q;
	logic        locked_q;
	logic [15:0] ctrl_q;
	logic        xfer_q;
	logic        flag_stb_q;
	logic [15:0] flag_data_q;

	// Link-side write capture, stable from frame end to next frame start
	logic [10:0] wr_addr_q;
	logic [15:0] wr_data_q;
	logic        wr_valid_q;

	level_sync #(.WIDTH(3)) u_strap_sync (
		.clk (CLK),
		.d   (STRAP_ADDR),
		.q   (strap_s)
	);

	level_sync #(.WIDTH(1)) u_cs_sync (
		.clk (CLK),
		.d   (CS_B),
		.q   (cs_b_s)
	);

	// Frame end qualifies the write words captured on the link side
	wire        frame_end = cs_b_s & ~cs_b_last_q;
	wire        apply     = frame_end & wr_valid_q;
	wire        wr_ctrl   = apply & (wr_addr_q == `CTRL_ADDR);
	wire        wr_lock   = apply & (wr_addr_q == `LOCK_ADDR);
	wire        wr_flag   = apply & (wr_addr_q == `FLAG_ADDR);
	wire        key_on    = wr_lock & (wr_data_q == `LOCK_KEY_ON);
	wire        key_off   = wr_lock & (wr_data_q == `LOCK_KEY_OFF);
	wire        reload    = wr_ctrl & wr_data_q[`CTRL_RELOAD_BIT];
	wire        ctrl_we   = wr_ctrl & ~locked_q;
	wire [15:0] ctrl_d    = ctrl_we ? (wr_data_q & `CTRL_WR_MASK) : ctrl_q;

	// Read images: revision is wired in, reload bit always reads zero
	wire [15:0] ctrl_rd = {ctrl_q[15:`REV_MSB+1], REVISION, ctrl_q[`REV_LSB-1:0]};

	// Strap captured one cycle after reset release and on reload
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			strap_load_q <= 1'b1;
			own_addr_q   <= 3'h0;
		end else begin
			strap_load_q <= 1'b0;
			if (strap_load_q || reload) begin
				own_addr_q <= strap_s;
			end
		end
	end

	// Control and lock state
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			cs_b_last_q <= 1'b1;
			ctrl_q      <= `CTRL_RESET;
			locked_q    <= 1'b0;
		end else begin
			cs_b_last_q <= cs_b_s;
			ctrl_q      <= ctrl_d;
			if (key_on) begin
				locked_q <= 1'b1;
			end else if (key_off) begin
				locked_q <= 1'b0;
			end
		end
	end

	// One-cycle strobes and the held flag value toward the rest of the chip
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			xfer_q      <= 1'b0;
			flag_stb_q  <= 1'b0;
			flag_data_q <= 16'h0000;
		end else begin
			xfer_q     <= key_on;
			flag_stb_q <= wr_flag;
			if (wr_flag) begin
				flag_data_q <= wr_data_q;
			end
		end
	end

	// ****************************************************************
	// Link side: header decode and shifting on the serial clock
	// ****************************************************************
	logic [19:0]               img_s;
	logic [5:0]                bit_cnt_q;
	logic [14:0]               sr_q;
	spi_lock_pkg::link_state_e st_q;
	spi_lock_pkg::link_state_e st_d;
	spi_lock_pkg::word_t       rd_word_q;
	spi_lock_pkg::word_t       crc_q;
	spi_lock_pkg::word_t       crc_w;
	logic                      crc_on_q;
	logic                      miso_q;
	logic                      oe_b_q;

	// Register image is quasi-static: it only moves right after a frame
	// ends, long before the next header completes
	level_sync #(.WIDTH(20)) u_img_sync (
		.clk (SCLK),
		.d   ({own_addr_q, locked_q, ctrl_rd}),
		.q   (img_s)
	);

	wire [2:0]  img_addr   = img_s[19:17];
	wire        img_locked = img_s[16];
	wire [15:0] img_ctrl   = img_s[15:0];

	wire [15:0] hdr       = {sr_q, MOSI};
	wire        hdr_done  = (bit_cnt_q == (`HDR_BITS - 6'd1));
	wire        hdr_rd    = hdr[`HDR_RW];
	wire        hdr_bcast = hdr[`HDR_BCAST];
	wire [10:0] hdr_reg   = hdr[`HDR_ADDR_MSB:`HDR_ADDR_LSB];
	wire [2:0]  hdr_chip  = hdr[`HDR_CHIP_MSB:`HDR_CHIP_LSB];

	// Broadcast reads are refused so that no two devices drive data out
	wire hdr_match = hdr_bcast ? ~hdr_rd : (hdr_chip == img_addr);

	// Register select for a read; unmapped addresses read as zero
	wire [15:0] rd_sel = (hdr_reg == `CTRL_ADDR) ? img_ctrl :
	                     (hdr_reg == `LOCK_ADDR) ? {15'h0000, img_locked} :
	                     16'h0000;

	crc16_word u_crc (
		.data (rd_sel),
		.crc  (crc_w)
	);

	// Frame phase after the header
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			spi_lock_pkg::ST_HDR: begin
				if (hdr_done) begin
					if (!hdr_match) begin
						st_d = spi_lock_pkg::ST_SKIP;
					end else if (hdr_rd) begin
						st_d = spi_lock_pkg::ST_RDATA;
					end else begin
						st_d = spi_lock_pkg::ST_WDATA;
					end
				end
			end
			spi_lock_pkg::ST_WDATA,
			spi_lock_pkg::ST_RDATA,
			spi_lock_pkg::ST_SKIP: begin
				st_d = st_q;
			end
		endcase
	end

	// Sampling on rising edge; chip select high aborts the frame
	always_ff @(posedge SCLK or posedge CS_B) begin
		if (CS_B) begin
			bit_cnt_q <= 6'h00;
			sr_q      <= 15'h0000;
			st_q      <= spi_lock_pkg::ST_HDR;
			rd_word_q <= 16'h0000;
			crc_q     <= 16'h0000;
			crc_on_q  <= 1'b0;
		end else begin
			sr_q  <= hdr[14:0];
			st_q  <= st_d;
			if (bit_cnt_q != `CNT_MAX) begin
				bit_cnt_q <= bit_cnt_q + 6'd1;
			end
			if (hdr_done) begin
				rd_word_q <= rd_sel;
				crc_q     <= crc_w;
				crc_on_q  <= img_ctrl[`CTRL_CRC_BIT];
			end
		end
	end

	// Write capture is kept through chip select high for the far side.
	// No reset here: valid starts unknown, but the system side only looks
	// at a frame end, and the first edge of every frame has cleared it.
	always_ff @(posedge SCLK) begin
		if (hdr_done) begin
			wr_addr_q <= hdr_reg;
		end
		if (bit_cnt_q == 6'd0) begin
			wr_valid_q <= 1'b0;
		end else if (bit_cnt_q == `FRAME_WR_LAST && st_q == spi_lock_pkg::ST_WDATA) begin
			wr_valid_q <= 1'b1;
			wr_data_q  <= hdr;
		end
	end

	// Transmit window: one word, then the checksum when enabled
	wire       tx_on  = (st_q == spi_lock_pkg::ST_RDATA) && (bit_cnt_q >= `HDR_BITS) &&
	                    ((bit_cnt_q < `TX_LAST_PLAIN) || (crc_on_q && bit_cnt_q < `TX_LAST_CRC));
	wire [5:0] tx_pos = `TX_LAST_CRC - 6'd1 - bit_cnt_q;
	wire [31:0] tx_frame = {rd_word_q, crc_q};

	// Data out changes on the falling edge
	always_ff @(negedge SCLK or posedge CS_B) begin
		if (CS_B) begin
			miso_q <= 1'b0;
			oe_b_q <= 1'b1;
		end else begin
			miso_q <= tx_on ? tx_frame[tx_pos[4:0]] : 1'b0;
			oe_b_q <= ~tx_on;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign MISO_O        = miso_q;
	assign MISO_OE_B     = oe_b_q | CS_B;
	assign CHIP_ADDR     = own_addr_q;
	assign LOCKED        = locked_q;
	assign CRC_EN        = ctrl_q[`CTRL_CRC_BIT];
	assign CTRL_CFG      = ctrl_q;
	assign CFG_XFER      = xfer_q;
	assign FLAG_CLR_STB  = flag_stb_q;
	assign FLAG_CLR_DATA = flag_data_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_reset_state: assert property (@(posedge CLK)
		!RST_B |=> !locked_q && !ctrl_q[`CTRL_CRC_BIT])
		else $error("lock or checksum enable not clear after reset");

	chk_strap_load: assert property (@(posedge CLK) disable iff (!RST_B)
		$rose(RST_B) |=> own_addr_q == $past(strap_s))
		else $error("strap address not taken after reset");

	chk_lock_key: assert property (@(posedge CLK) disable iff (!RST_B)
		key_on |=> locked_q && CFG_XFER ##1 !CFG_XFER)
		else $error("lock key did not lock and pulse transfer");

	chk_unlock_key: assert property (@(posedge CLK) disable iff (!RST_B)
		key_off |=> !locked_q)
		else $error("unlock key did not clear protection");

	chk_locked_drop: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_ctrl && locked_q |=> $stable(ctrl_q))
		else $error("control changed while locked");

	chk_flag_open: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_flag && locked_q |=> FLAG_CLR_STB && FLAG_CLR_DATA == $past(wr_data_q))
		else $error("flag register write lost while locked");

	chk_bcast_take: assert property (@(posedge SCLK) disable iff (CS_B)
		hdr_done && hdr_bcast && !hdr_rd |=> st_q == spi_lock_pkg::ST_WDATA)
		else $error("broadcast write not accepted");

	chk_bcast_read: assert property (@(posedge SCLK) disable iff (CS_B)
		hdr_done && hdr_bcast && hdr_rd |=> st_q == spi_lock_pkg::ST_SKIP)
		else $error("broadcast read not refused");

	chk_addr_miss: assert property (@(posedge SCLK) disable iff (CS_B)
		hdr_done && !hdr_bcast && hdr_chip != img_addr |=> st_q == spi_lock_pkg::ST_SKIP)
		else $error("foreign chip address accepted");

	chk_first_bit: assert property (@(posedge SCLK) disable iff (CS_B)
		st_q == spi_lock_pkg::ST_RDATA && bit_cnt_q == `HDR_BITS
		|-> !oe_b_q && miso_q == rd_word_q[15])
		else $error("first read bit not driven after header");

	chk_one_word: assert property (@(posedge SCLK) disable iff (CS_B)
		st_q == spi_lock_pkg::ST_RDATA &&
		bit_cnt_q >= (crc_on_q ? `TX_LAST_CRC : `TX_LAST_PLAIN) |-> oe_b_q)
		else $error("data out driven past end of read");

	chk_crc_zero: assert property (@(posedge SCLK) disable iff (CS_B)
		st_q == spi_lock_pkg::ST_RDATA && rd_word_q == 16'h0000 |-> crc_q == 16'h1d0f)
		else $error("checksum of zero word wrong");

endmodule // spi_register_access_lock

`default_nettype wire

// ### dv/spi_host_model.sv
`default_nettype none

// ****************************************************************
// Serial host: drives frames, samples the data-out line
// ****************************************************************
module spi_host_model (
	output logic      sclk,      // Serial clock, idle high, still outside frames
	output logic      cs_b,      // Chip select, active low
	output logic      mosi,      // Serial data to the device
	input  wire logic miso_o,    // Device data-out value
	input  wire logic miso_oe_b  // Device data-out enable, low drives
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam realtime HALF = 62.5; // 8 MHz, under the 10 MHz ceiling
	localparam realtime GAP  = 250.0; // Chip select high time between frames

	logic last_q = 1'b0; // Last value the device drove, taken at sample time

	// Idle bus; one chip select rise early on clears the link side
	initial begin
		sclk = 1'b1;
		cs_b = 1'b0;
		mosi = 1'b0;
		#10;
		cs_b = 1'b1;
	end

	// One frame: header then word, MSB first; fewer bits makes an abort
	task automatic xfer(input logic [15:0] hdr, input logic [15:0] wd, input int nbits,
			output logic [31:0] rd, output logic drv);
		logic [47:0] sh;
		sh  = {hdr, wd, 16'h0000};
		rd  = '0;
		drv = 1'b0;
		#7;
		cs_b = 1'b0;
		#(HALF);
		for (int i = 0; i < nbits; i++) begin
			sclk = 1'b0;
			mosi = sh[47-i]; // Shift on falling edge
			#(HALF);
			sclk = 1'b1;
			// Released line has no pull: it shows the inverse of the last driven value
			if (i >= 16) begin
				rd = {rd[30:0], (miso_oe_b === 1'b0) ? miso_o : ~last_q}; // Sample on rise
				if (miso_oe_b === 1'b0) begin
					last_q = miso_o;
					drv    = 1'b1;
				end
			end
			#(HALF);
		end
		cs_b = 1'b1;
		mosi = 1'b0;
		#(GAP);
	endtask
endmodule // spi_host_model

`default_nettype wire

// ### dv/tb.sv
`include "spi_lock_defs.svh"
`default_nettype none

// ****************************************************************
// Self-checking bench for the serial register front end
// ****************************************************************
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic        CLK;
	logic        RST_B;
	logic [2:0]  STRAP_ADDR;
	wire         SCLK, CS_B, MOSI, MISO_O, MISO_OE_B, LOCKED, CRC_EN, CFG_XFER, FLAG_CLR_STB;
	wire  [2:0]  CHIP_ADDR;
	wire  [15:0] CTRL_CFG, FLAG_CLR_DATA;
	int          error_cnt, check_count, x0;
	int          xfer_seen = 0;
	int          flag_seen = 0;
	logic [31:0] r;
	logic        dv;

	spi_register_access_lock spi_register_access_lock_inst (
		.CLK(CLK), .RST_B(RST_B), .STRAP_ADDR(STRAP_ADDR), .SCLK(SCLK), .CS_B(CS_B),
		.MOSI(MOSI), .MISO_O(MISO_O), .MISO_OE_B(MISO_OE_B), .CHIP_ADDR(CHIP_ADDR),
		.LOCKED(LOCKED), .CRC_EN(CRC_EN), .CTRL_CFG(CTRL_CFG), .CFG_XFER(CFG_XFER),
		.FLAG_CLR_STB(FLAG_CLR_STB), .FLAG_CLR_DATA(FLAG_CLR_DATA)
	);

	spi_host_model spi_host_model_inst (
		.sclk(SCLK), .cs_b(CS_B), .mosi(MOSI), .miso_o(MISO_O), .miso_oe_b(MISO_OE_B)
	);

	// System clock, 25 MHz
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end

	// Count one-cycle pulses so a missing or doubled pulse shows
	always @(posedge CLK) begin
		if (CFG_XFER === 1'b1) xfer_seen++;
		if (FLAG_CLR_STB === 1'b1) flag_seen++;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Reference checksum: seed all ones, word bit 15 first, taps 0, 5 and 12
	function automatic logic [15:0] crc_of(input logic [15:0] w);
		logic [15:0] b;
		logic        fb;
		b = 16'hffff;
		for (int i = 15; i >= 0; i--) begin
			fb = w[i] ^ b[15];
			b  = {b[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
		end
		return b;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask

	// Write frame; short counts cut the frame before commit, then let the CLK side settle
	task automatic wr(input logic bc, input logic [10:0] a, input logic [2:0] c,
			input logic [15:0] d, input int n = 32);
		logic [31:0] rr;
		logic        dd;
		spi_host_model_inst.xfer({bc, a, 1'b0, c}, d, n, rr, dd);
		repeat (6) @(posedge CLK);
		#2;
	endtask

	task automatic rdr(input logic [10:0] a, input logic [2:0] c, input int n,
			output logic [31:0] rv, output logic dr);
		spi_host_model_inst.xfer({1'b0, a, 1'b1, c}, 16'h0000, n, rv, dr);
	endtask

	task automatic set_strap(input logic [2:0] v);
		@(posedge CLK);
		#2 STRAP_ADDR = v;
	endtask

	task automatic end_of_test;
		$display("errors=%0d checks=%0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		RST_B = 1'b0;
		STRAP_ADDR = 3'h5;
		error_cnt = 0;
		check_count = 0;
		repeat (6) @(posedge CLK);
		#2 RST_B = 1'b1;
		repeat (6) @(posedge CLK);
		#2;
		chk(LOCKED, 0);
		chk({CRC_EN, CTRL_CFG}, 0);
		chk(CHIP_ADDR, 3'h5);
		rdr(`CTRL_ADDR, 3'h5, 32, r, dv);
		chk(r[15:0], 16'h0020);
		rdr(`CTRL_ADDR, 3'h2, 32, r, dv);
		chk(dv, 1'b0);
		spi_host_model_inst.xfer({1'b1, `CTRL_ADDR, 1'b1, 3'h5}, 16'h0000, 32, r, dv);
		chk(dv, 1'b0);
		// Extra clocks after the word must find data out released
		rdr(11'h7ff, 3'h5, 48, r, dv);
		chk(r, {16'h0000, 16'hffff});
		// All ones: revision and reload stay out of storage
		wr(1'b0, `CTRL_ADDR, 3'h5, 16'hffff);
		chk(CTRL_CFG, 16'hfe1d);
		chk(CRC_EN, 1'b1);
		rdr(`CTRL_ADDR, 3'h5, 48, r, dv);
		chk(r, {16'hfe3d, crc_of(16'hfe3d)});
		wr(1'b0, `CTRL_ADDR, 3'h2, 16'h0000);
		chk(CTRL_CFG, 16'hfe1d);
		wr(1'b1, `CTRL_ADDR, 3'h2, 16'h0000);
		chk(CTRL_CFG, 16'h0000);
		rdr(`CTRL_ADDR, 3'h5, 32, r, dv);
		chk(r[15:0], 16'h0020);
		// Frame cut at bit 20 must change nothing
		wr(1'b0, `CTRL_ADDR, 3'h5, 16'h0011, 20);
		chk(CTRL_CFG, 16'h0000);
		chk(MISO_OE_B, 1'b1);
		// Lock, then confirm by readback
		x0 = xfer_seen;
		wr(1'b0, `LOCK_ADDR, 3'h5, 16'hade1);
		chk(LOCKED, 1'b1);
		chk(32'(xfer_seen - x0), 1);
		rdr(`LOCK_ADDR, 3'h5, 32, r, dv);
		chk(r[15:0], 16'h0001);
		wr(1'b0, `CTRL_ADDR, 3'h5, 16'h0011);
		chk(CTRL_CFG, 16'h0000);
		set_strap(3'h7);
		wr(1'b0, `CTRL_ADDR, 3'h5, 16'h0002);
		chk(CHIP_ADDR, 3'h7);
		wr(1'b0, `FLAG_ADDR, 3'h7, 16'h1234);
		chk(FLAG_CLR_DATA, 16'h1234);
		chk(32'(flag_seen), 1);
		wr(1'b0, `LOCK_ADDR, 3'h7, 16'h1234);
		chk(LOCKED, 1'b1);
		wr(1'b0, `LOCK_ADDR, 3'h7, 16'hade0);
		chk(LOCKED, 1'b0);
		wr(1'b0, `CTRL_ADDR, 3'h7, 16'h0011);
		chk(CTRL_CFG, 16'h0011);
		set_strap(3'h0);
		wr(1'b0, `CTRL_ADDR, 3'h7, 16'h0002);
		chk(CHIP_ADDR, 3'h0);
		end_of_test();
	end

	// Whole run needs well under half a millisecond
	initial begin
		#2000000;
		error_cnt++;
		end_of_test();
	end
endmodule // tb

`default_nettype wire
